/* File: core/sar_params.svh */
/*
 * timing, field positions, offsets and reset values for the converter
 * control block; assumes it is included once per compilation unit.
 */
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH
`define CLK_MHZ         25
`define MIN_PERIOD_NS   2000
`define MIN_PERIOD_CYC  ((`MIN_PERIOD_NS * `CLK_MHZ + 999) / 1000)
`define FRAME_BITS      16
`define CODE_BITS       13
`define TRACK_EDGE      14
`define SIGN_FLIP       13'h1000
`define TRIAL_MSB       13'h1000
`define WR_BIT          15
`define SEL_BIT         14
`define CTRL_MODE_HI    12
`define CTRL_MODE_LO    11
`define CTRL_CODING     10
`define CTRL_REF        9
`define CTRL_PM_HI      8
`define CTRL_PM_LO      7
`define CTRL_SEQ        6
`define CTRL_CH         5
`define RNG0_HI         12
`define RNG0_LO         11
`define RNG1_HI         10
`define RNG1_LO         9
`define APB_AW          8
`define OFS_CTRL        8'h00
`define OFS_RANGE       8'h04
`define OFS_STATUS      8'h08
`define OFS_DATA        8'h0C
`define RST_RANGE       4'h0
`define ST_EMPTY        0
`define ST_COUNT_LO     1
`define ST_TRACK        6
`define ST_PD           7
`define ST_RATE_ERR     8
`define ST_BUSY         9
`endif

/* File: core/sar_pkg.sv */
/*
 * types shared by the converter control block; assumes sar_params.svh
 * holds the numeric constants.
 */
package sar_pkg;
	typedef enum logic [1:0] {RANGE_BIP10, RANGE_BIP5, RANGE_BIP2P5,
		RANGE_UNI10} range_t;
	typedef enum logic [1:0] {MODE_SINGLE, MODE_DIFF, MODE_PSEUDO,
		MODE_SPARE} mode_t;
	typedef enum logic [1:0] {PM_NORMAL, PM_FULL, PM_AUTO_SD,
		PM_AUTO_SB} pm_t;
	typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_TRACK} sar_state_t;
endpackage

/* File: core/sar_ctrl.sv */
/*
 * result fifo and the serial-clocked conversion control with its apb
 * register window. assumes cs_n, sclk, din and comp_in come from outside
 * the pclk domain and that the link clock is far slower than pclk.
 */
// What this block does
// - each channel keeps its own range, bipolar or unipolar, in registers.
// - two control bits pick single-ended, true differential or pseudo.
// - after reset inputs are two single-ended channels until rewritten.
// - after reset the external reference is used.
// - the serial clock shifts data and steps the conversion.
// - power-down mode comes from the control register.
// - results default to twos complement.
// - coding bit set gives straight binary results.
// - sequence conversions use the coding bit of the latest write.
// - full scale is split into 8192 codes of whole steps.
// - step size follows the selected range of the channel.
// - trial bits are kept or dropped by the comparator, then code formed.
// - conversions faster than 500 ksps are refused.
// - track on fourteenth rising edge, hold on next chip select fall.
// - differential modes span code -4096 to +4095.
`timescale 1ns/1ps
`include "sar_params.svh"

module result_fifo #(
	parameter int W     = 14,
	parameter int DEPTH = 16
) (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       ce,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [W-1:0]               in_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [W-1:0]                    out_data,
	output logic [$clog2(DEPTH):0]          count
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  mem [DEPTH];
	logic [AW:0]   wr_q, wr_d, rd_q, rd_d;
	logic          push, pop;

	always_comb begin
		count     = wr_q - rd_q;
		in_ready  = count != (AW+1)'(DEPTH);
		out_valid = count != '0;
		out_data  = mem[rd_q[AW-1:0]];
		push      = in_valid && in_ready;
		pop       = out_valid && out_ready;
		wr_d      = push ? wr_q + 1'b1 : wr_q;
		rd_d      = pop ? rd_q + 1'b1 : rd_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_q <= '0;
			rd_q <= '0;
		end else if (ce) begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			if (push) begin
				mem[wr_q[AW-1:0]] <= in_data;
			end
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////
module sar_ctrl #(
	parameter int DEPTH = 16
) (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     ce,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [`APB_AW-1:0]       paddr,
	input  wire logic [31:0]              pwdata,
	output logic [31:0]                   prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic                     cs_n,
	input  wire logic                     sclk,
	input  wire logic                     din,
	input  wire logic                     comp_in,
	output logic                          dout,
	output logic                          dout_en_n,
	output logic                          track,
	output logic [`CODE_BITS-1:0]         dac_code,
	output sar_pkg::range_t               range_sel,
	output sar_pkg::mode_t                input_mode,
	output logic                          ref_internal,
	output logic                          power_down
);
	import sar_pkg::*;
	localparam int CW    = `CODE_BITS;
	localparam int DW    = CW + 1;
	localparam int CNTW  = $clog2(DEPTH) + 1;
	localparam int GAPW  = $clog2(`MIN_PERIOD_CYC + 1);
	localparam logic [GAPW-1:0] GAP_MAX = GAPW'(`MIN_PERIOD_CYC);
	localparam logic [4:0] EDGE_TRK = 5'(`TRACK_EDGE - 1);

	// bit 0 cs_n, 1 sclk, 2 din, 3 comparator
	logic [3:0]   s1_q, s2_q, prev_q;
	logic         cs_fall, cs_rise, sclk_rise, sclk_fall;

	sar_state_t   st_q, st_d;
	logic [4:0]   edge_q, edge_d;
	logic [CW-1:0] sar_q, sar_d, trial_q, trial_d, dac_q, dac_d;
	logic [15:0]  shin_q, shin_d, dsh_q, dsh_d;
	logic         dout_q, dout_d, den_q, den_d, track_q, track_d;
	logic         pd_q, pd_d, rate_q, rate_d, cfgw_q, cfgw_d;
	mode_t        mode_q, mode_d;
	pm_t          pm_q, pm_d;
	range_t       rsel_q, rsel_d;
	logic         coding_q, coding_d, ref_q, ref_d, seq_q, seq_d;
	logic         ch_q, ch_d, cch_q, cch_d, ccod_q, ccod_d;
	logic [3:0]   range_q, range_d;
	logic [GAPW-1:0] gap_q, gap_d;
	logic [DW-1:0] last_q, last_d;
	logic         start_ok, push, fifo_rdy, fifo_vld, pop;
	logic [DW-1:0] push_data, fifo_out;
	logic [CNTW-1:0] fifo_cnt;
	logic [CW-1:0] raw;
	logic         apb_done, apb_wr;
	logic         prdy_q, prdy_d, perr_q, perr_d;
	logic [31:0]  prd_q, prd_d, status;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////
	// link pins: two flops before any logic, then edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q   <= 4'h3;
			s2_q   <= 4'h3;
			prev_q <= 4'h3;
		end else if (ce) begin
			s1_q   <= {comp_in, din, sclk, cs_n};
			s2_q   <= s1_q;
			prev_q <= s2_q;
		end
	end

	always_comb begin
		cs_fall   = prev_q[0] && !s2_q[0];
		cs_rise   = !prev_q[0] && s2_q[0];
		sclk_rise = !prev_q[1] && s2_q[1] && !s2_q[0];
		sclk_fall = prev_q[1] && !s2_q[1] && !s2_q[0];
	end

	result_fifo #(.W(DW), .DEPTH(DEPTH)) result_fifo_inst (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.in_valid  (push),
		.in_ready  (fifo_rdy),
		.in_data   (push_data),
		.out_valid (fifo_vld),
		.out_ready (pop),
		.out_data  (fifo_out),
		.count     (fifo_cnt)
	);

	////////////////////////////////////////////////////////////////////
	// conversion, serial shifting and configuration
	always_comb begin
		st_d = st_q; edge_d = edge_q; sar_d = sar_q; trial_d = trial_q;
		shin_d = shin_q; dsh_d = dsh_q; dout_d = dout_q;
		track_d = track_q; pd_d = pd_q; rate_d = rate_q; cfgw_d = cfgw_q;
		mode_d = mode_q; pm_d = pm_q; coding_d = coding_q; ref_d = ref_q;
		seq_d = seq_q; ch_d = ch_q; cch_d = cch_q; ccod_d = ccod_q;
		range_d = range_q; last_d = last_q; push = 1'b0;
		gap_d = (gap_q == GAP_MAX) ? gap_q : gap_q + 1'b1;
		den_d = s2_q[0];
		// 13-bit offset code, 8192 steps; flipping the sign bit gives
		// twos complement, -4096..+4095 in differential modes
		raw = sar_q;
		push_data = {cch_q, ccod_q ? raw : raw ^ `SIGN_FLIP};
		// a full fifo stalls new conversions rather than losing results
		start_ok = (gap_q == GAP_MAX) && fifo_rdy && pm_q != PM_FULL;
		if (cs_fall) begin
			edge_d = '0;
			shin_d = '0;
			dsh_d  = 16'({last_q});
			dout_d = 1'b0;
			if (gap_q != GAP_MAX) begin
				rate_d = 1'b1;
			end
			if (start_ok) begin
				st_d    = ST_CONV;
				track_d = 1'b0;
				pd_d    = 1'b0;
				gap_d   = '0;
				sar_d   = '0;
				trial_d = `TRIAL_MSB;
				cch_d   = ch_q;
				ccod_d  = coding_q;
			end
		end
		if (sclk_rise) begin
			edge_d = (edge_q == 5'h1F) ? edge_q : edge_q + 1'b1;
			if (st_q == ST_CONV) begin
				// one comparator decision per rising serial clock edge
				if (edge_q < 5'(`CODE_BITS)) begin
					if (s2_q[3]) begin
						sar_d = sar_q | trial_q;
					end
					trial_d = trial_q >> 1;
				end else if (edge_q == EDGE_TRK) begin
					st_d    = ST_TRACK;
					track_d = 1'b1;
					push    = 1'b1;
					last_d  = push_data;
					if (seq_q) begin
						ch_d = !cch_q;
					end
				end
			end
		end
		if (sclk_fall) begin
			shin_d = {shin_q[14:0], s2_q[2]};
			dsh_d  = {dsh_q[14:0], 1'b0};
			dout_d = dsh_q[14];
		end
		// lower priority: a serial write in the same cycle wins
		if (apb_wr && paddr == `OFS_CTRL) begin
			mode_d   = mode_t'(pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO]);
			coding_d = pwdata[`CTRL_CODING];
			ref_d    = pwdata[`CTRL_REF];
			pm_d     = pm_t'(pwdata[`CTRL_PM_HI:`CTRL_PM_LO]);
			seq_d    = pwdata[`CTRL_SEQ];
			ch_d     = pwdata[`CTRL_CH];
			cfgw_d   = 1'b1;
		end
		if (apb_wr && paddr == `OFS_RANGE) begin
			range_d = pwdata[`RNG0_HI:`RNG1_LO];
		end
		if (apb_wr && paddr == `OFS_STATUS && pwdata[`ST_RATE_ERR] &&
				!(cs_fall && gap_q != GAP_MAX)) begin
			rate_d = 1'b0;
		end
		if (cs_rise) begin
			st_d    = ST_IDLE;
			track_d = 1'b1;
			if (pm_q == PM_AUTO_SD || pm_q == PM_AUTO_SB) begin
				pd_d = 1'b1;
			end
			// only a whole word under chip select is taken
			if (edge_q >= 5'(`FRAME_BITS) && shin_q[`WR_BIT]) begin
				if (!shin_q[`SEL_BIT]) begin
					mode_d   = mode_t'(shin_q[`CTRL_MODE_HI:`CTRL_MODE_LO]);
					coding_d = shin_q[`CTRL_CODING];
					ref_d    = shin_q[`CTRL_REF];
					pm_d     = pm_t'(shin_q[`CTRL_PM_HI:`CTRL_PM_LO]);
					seq_d    = shin_q[`CTRL_SEQ];
					ch_d     = shin_q[`CTRL_CH];
					cfgw_d   = 1'b1;
				end else begin
					range_d = shin_q[`RNG0_HI:`RNG1_LO];
				end
			end
		end
		// selecting normal mode wakes the part without waiting for a frame
		pd_d = (pm_q == PM_FULL) || (pd_d && pm_q != PM_NORMAL);
		dac_d = sar_d | trial_d;
		// range of the channel being converted sets the step size
		rsel_d = range_t'(cch_d ? range_q[1:0] : range_q[3:2]);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ST_IDLE; edge_q <= '0; sar_q <= '0; trial_q <= '0;
			dac_q <= '0; shin_q <= '0; dsh_q <= '0; dout_q <= 1'b0;
			den_q <= 1'b1; track_q <= 1'b1; pd_q <= 1'b0; rate_q <= 1'b0;
			cfgw_q <= 1'b0; mode_q <= MODE_SINGLE; pm_q <= PM_NORMAL;
			coding_q <= 1'b0; ref_q <= 1'b0; seq_q <= 1'b0;
			ch_q <= 1'b0; cch_q <= 1'b0; ccod_q <= 1'b0;
			range_q <= `RST_RANGE; rsel_q <= RANGE_BIP10;
			gap_q <= GAP_MAX; last_q <= '0;
		end else if (ce) begin
			st_q <= st_d; edge_q <= edge_d; sar_q <= sar_d;
			trial_q <= trial_d; dac_q <= dac_d; shin_q <= shin_d;
			dsh_q <= dsh_d; dout_q <= dout_d; den_q <= den_d;
			track_q <= track_d; pd_q <= pd_d; rate_q <= rate_d;
			cfgw_q <= cfgw_d; mode_q <= mode_d; pm_q <= pm_d;
			coding_q <= coding_d; ref_q <= ref_d; seq_q <= seq_d;
			ch_q <= ch_d; cch_q <= cch_d; ccod_q <= ccod_d;
			range_q <= range_d; rsel_q <= rsel_d;
			gap_q <= gap_d; last_q <= last_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// apb slave: one wait state so read data comes from a flop
	always_comb begin
		apb_done = psel && penable && prdy_q;
		apb_wr   = apb_done && pwrite && !perr_q;
		pop      = apb_done && !pwrite && paddr == `OFS_DATA && fifo_vld;
		status   = 32'(fifo_cnt) << `ST_COUNT_LO;
		status[`ST_EMPTY]    = !fifo_vld;
		status[`ST_TRACK]    = track_q;
		status[`ST_PD]       = pd_q;
		status[`ST_RATE_ERR] = rate_q;
		status[`ST_BUSY]     = st_q == ST_CONV;
		prdy_d = psel && penable && !prdy_q;
		perr_d = 1'b0;
		prd_d  = '0;
		if (prdy_d) begin
			unique case (paddr)
				`OFS_CTRL: prd_d = 32'({mode_q, coding_q, ref_q, pm_q,
					seq_q, ch_q}) << `CTRL_CH;
				`OFS_RANGE: prd_d = 32'(range_q) << `RNG1_LO;
				`OFS_STATUS: prd_d = status;
				`OFS_DATA: prd_d = fifo_vld ? 32'(fifo_out) : '0;
				default: perr_d = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdy_q <= 1'b0;
			perr_q <= 1'b0;
			prd_q  <= '0;
		end else if (ce) begin
			prdy_q <= prdy_d;
			perr_q <= perr_d;
			prd_q  <= prd_d;
		end
	end

	always_comb begin
		prdata = prd_q; pready = prdy_q; pslverr = perr_q;
		dout = dout_q; dout_en_n = den_q; track = track_q;
		dac_code = dac_q; range_sel = rsel_q; input_mode = mode_q;
		ref_internal = ref_q; power_down = pd_q;
	end

	////////////////////////////////////////////////////////////////////
	track_edge_a: assert property (ce && sclk_rise && st_q == ST_CONV &&
		edge_q == EDGE_TRK && !cs_rise |=> track_q && st_q == ST_TRACK)
		else $error("no track on fourteenth edge");
	hold_on_cs_a: assert property (ce && cs_fall && start_ok |=>
		!track_q && st_q == ST_CONV && trial_q == `TRIAL_MSB)
		else $error("no hold at chip select fall");
	sar_step_a: assert property (ce && sclk_rise && st_q == ST_CONV &&
		edge_q < 5'(`CODE_BITS) && !cs_rise |=> trial_q == $past(trial_q) >> 1)
		else $error("trial bit did not advance");
	twos_code_a: assert property (push && !ccod_q |->
		push_data[CW-1] != sar_q[CW-1] &&
		push_data[CW-2:0] == sar_q[CW-2:0])
		else $error("twos complement code wrong");
	binary_code_a: assert property (push && ccod_q |->
		push_data[CW-1:0] == sar_q && fifo_rdy)
		else $error("straight binary code wrong");
	seq_coding_a: assert property (ce && cs_fall && start_ok |=>
		ccod_q == $past(coding_q))
		else $error("coding not taken from last write");
	reset_cfg_a: assert property (!cfgw_q |->
		mode_q == MODE_SINGLE && !ref_q && input_mode == MODE_SINGLE)
		else $error("power-up configuration lost");
	rate_guard_a: assert property (ce && cs_fall && gap_q != GAP_MAX |=>
		st_q != ST_CONV || $past(st_q) == ST_CONV)
		else $error("conversion started too soon");
	pd_block_a: assert property (ce && cs_fall && pm_q == PM_FULL &&
		st_q != ST_CONV |=> st_q != ST_CONV ##1 pd_q)
		else $error("conversion in full power-down");
endmodule

/* File: verification/serial_host.sv */
/*
 * far end of the serial link: frames, serial clock, write words and a
 * comparator model. assumes pclk of the block under test drives it.
 */
`timescale 1ns/1ps
`include "sar_params.svh"

module serial_host (
	input  wire logic                 pclk,
	input  wire logic [`CODE_BITS-1:0] dac_code,
	input  wire logic [`CODE_BITS-1:0] target,
	input  wire logic                 dout,
	output logic                      cs_n,
	output logic                      sclk,
	output logic                      din,
	output logic                      comp_in
);
	// last sixteen dout bits, taken just before each rising sclk
	logic [15:0] rx;

	// link idles with sclk high; it never runs outside a frame
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		din = 1'b0;
		comp_in = 1'b0;
	end

	// keep a trial bit while the trial code is not above the input
	always @(posedge pclk) begin
		comp_in <= (dac_code <= target);
	end

	////////////////////////////////////////////////////////////////////
	task automatic begin_frame;
		@(posedge pclk);
		cs_n <= 1'b0;
		repeat (6) @(posedge pclk);
	endtask

	// 320 ns link period; din moves while sclk is high, MSB first
	task automatic shift(input logic [15:0] w, input int n);
		for (int i = 0; i < n; i++) begin
			din <= w[15-i];
			@(posedge pclk);
			sclk <= 1'b0;
			repeat (4) @(posedge pclk);
			rx = {rx[14:0], dout};
			sclk <= 1'b1;
			repeat (3) @(posedge pclk);
		end
	endtask

	// deselected data line shows the inverse so a stale bit is never read
	task automatic end_frame;
		repeat (2) @(posedge pclk);
		cs_n <= 1'b1;
		din <= ~din;
		repeat (4) @(posedge pclk);
	endtask
endmodule

/* File: verification/tb_sar_ctrl.sv */
/*
 * self-checking bench for sar_ctrl: apb master tasks, one task per
 * scenario. assumes serial_host plays the far end of the link.
 */
`timescale 1ns/1ps
`include "sar_params.svh"

module tb_sar_ctrl;
	import sar_pkg::*;
	logic                   pclk;
	logic                   presetn;
	logic                   psel;
	logic                   penable;
	logic                   pwrite;
	logic [`APB_AW-1:0]     paddr;
	logic [31:0]            pwdata;
	logic [31:0]            prdata;
	logic                   pready;
	logic                   pslverr;
	logic                   cs_n;
	logic                   sclk;
	logic                   din;
	logic                   comp_in;
	logic                   dout;
	logic                   dout_en_n;
	logic                   track;
	logic [`CODE_BITS-1:0]  dac_code;
	logic [`CODE_BITS-1:0]  target;
	range_t                 range_sel;
	mode_t                  input_mode;
	logic                   ref_internal;
	logic                   power_down;
	int                     failures;
	int                     cmp_count;
	logic [31:0]            r;
	logic                   e;

	sar_ctrl #(.DEPTH(16)) sar_ctrl_inst (
		.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cs_n(cs_n), .sclk(sclk), .din(din),
		.comp_in(comp_in), .dout(dout), .dout_en_n(dout_en_n),
		.track(track), .dac_code(dac_code), .range_sel(range_sel),
		.input_mode(input_mode), .ref_internal(ref_internal),
		.power_down(power_down));

	serial_host serial_host_inst (
		.pclk(pclk), .dac_code(dac_code), .target(target), .dout(dout),
		.cs_n(cs_n), .sclk(sclk), .din(din), .comp_in(comp_in));

	initial pclk = 1'b0;
	always #20 pclk = ~pclk;

	////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got,
				exp);
		end
	endtask

	// request held until pready is sampled high, released after that edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic conv(input logic [12:0] t, input logic [15:0] w,
		input int n, input logic ok, input range_t rs);
		target <= t;
		serial_host_inst.begin_frame();
		chk({track, dout_en_n}, {!ok, 1'b0});
		if (ok) chk(range_sel, rs);
		serial_host_inst.shift(w, n);
		if (n == 16) chk(track, 1'b1);
		serial_host_inst.end_frame();
	endtask

	task automatic pop(input logic ch, input logic [12:0] c);
		apb(1'b0, `OFS_DATA, 32'h0000_0000);
		chk(r, {18'h0_0000, ch, c});
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk(input_mode, MODE_SINGLE);
		chk({ref_internal, power_down}, 2'b00);
		apb(1'b0, `OFS_CTRL, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		apb(1'b0, `OFS_RANGE, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk({31'h0, e}, 32'h0000_0001);
	endtask

	task automatic t_config;
		for (int m = 0; m < 3; m++) begin
			apb(1'b1, `OFS_CTRL, 32'(m) << `CTRL_MODE_LO);
			apb(1'b0, `OFS_CTRL, 32'h0000_0000);
			chk(input_mode, 32'(m));
		end
		apb(1'b1, `OFS_CTRL, 32'h0000_0280);
		apb(1'b0, `OFS_STATUS, 32'h0000_0000);
		chk({ref_internal, power_down, r[`ST_PD]}, 3'b111);
		apb(1'b1, `OFS_CTRL, 32'h0000_0000);
		apb(1'b0, `OFS_STATUS, 32'h0000_0000);
		chk({ref_internal, power_down}, 2'b00);
	endtask

	task automatic t_coding;
		conv(13'h00A5, 16'h0000, 16, 1'b1, RANGE_BIP10);
		pop(1'b0, 13'h00A5 ^ `SIGN_FLIP);
		apb(1'b1, `OFS_CTRL, 32'h0000_0400);
		conv(13'h1F3C, 16'h0000, 16, 1'b1, RANGE_BIP10);
		chk(serial_host_inst.rx, {2'b00, 13'h00A5 ^ `SIGN_FLIP, 1'b0});
		pop(1'b0, 13'h1F3C);
	endtask

	task automatic t_sequence;
		apb(1'b1, `OFS_RANGE, 32'h0000_0E00);
		apb(1'b0, `OFS_RANGE, 32'h0000_0000);
		chk(r, 32'h0000_0E00);
		apb(1'b1, `OFS_CTRL, 32'h0000_0440);
		conv(13'h0000, 16'h0000, 16, 1'b1, RANGE_BIP5);
		conv(13'h1FFF, 16'h0000, 16, 1'b1, RANGE_UNI10);
		pop(1'b0, 13'h0000);
		pop(1'b1, 13'h1FFF);
		apb(1'b1, `OFS_CTRL, 32'h0000_0040);
		conv(13'h0123, 16'h0000, 16, 1'b1, RANGE_BIP5);
		pop(1'b0, 13'h0123 ^ `SIGN_FLIP);
	endtask

	// an aborted frame still starts the rate gap, so the next is refused
	task automatic t_rate;
		apb(1'b1, `OFS_CTRL, 32'h0000_0000);
		conv(13'h0010, 16'h0000, 2, 1'b1, RANGE_BIP5);
		conv(13'h0010, 16'h0000, 16, 1'b0, RANGE_BIP5);
		apb(1'b0, `OFS_STATUS, 32'h0000_0000);
		chk({r[8], r[5:0]}, 7'h41);
		apb(1'b1, `OFS_STATUS, 32'h0000_0100);
		apb(1'b0, `OFS_STATUS, 32'h0000_0000);
		chk(r[8], 1'b0);
		repeat (60) @(posedge pclk);
	endtask

	task automatic t_serial;
		conv(13'h0001, 16'h9000, 16, 1'b1, RANGE_BIP5);
		apb(1'b0, `OFS_CTRL, 32'h0000_0000);
		chk(r, 32'h0000_1000);
		chk(input_mode, MODE_PSEUDO);
		pop(1'b0, 13'h0001 ^ `SIGN_FLIP);
		conv(13'h0000, 16'h0000, 16, 1'b1, RANGE_BIP5);
		conv(13'h1FFF, 16'h0000, 16, 1'b1, RANGE_BIP5);
		pop(1'b0, 13'h1000);
		pop(1'b0, 13'h0FFF);
	endtask

	// full shutdown refuses a frame; auto modes power down at frame end
	task automatic t_power;
		apb(1'b1, `OFS_CTRL, 32'h0000_0080);
		conv(13'h0777, 16'h0000, 16, 1'b0, RANGE_BIP5);
		apb(1'b0, `OFS_STATUS, 32'h0000_0000);
		chk({r[`ST_PD], r[5:0]}, 7'h41);
		for (int m = 2; m < 4; m++) begin
			apb(1'b1, `OFS_CTRL, 32'(m) << `CTRL_PM_LO);
			conv(13'h0777, 16'h0000, 16, 1'b1, RANGE_BIP5);
			chk(power_down, 1'b1);
			pop(1'b0, 13'h0777 ^ `SIGN_FLIP);
		end
		apb(1'b1, `OFS_CTRL, 32'h0000_0000);
		apb(1'b0, `OFS_STATUS, 32'h0000_0000);
		chk({power_down, r[`ST_PD]}, 2'b00);
	endtask

	task automatic t_fifo;
		apb(1'b1, `OFS_CTRL, 32'h0000_0000);
		for (int i = 0; i < 17; i++)
			conv(13'(i * 257), 16'h0000, 16, i < 16, RANGE_BIP5);
		apb(1'b0, `OFS_STATUS, 32'h0000_0000);
		chk(r[5:0], 6'h20);
		for (int i = 0; i < 16; i++)
			pop(1'b0, 13'(i * 257) ^ `SIGN_FLIP);
		apb(1'b0, `OFS_DATA, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		apb(1'b0, `OFS_STATUS, 32'h0000_0000);
		chk(r[5:0], 6'h01);
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		target = '0;
		failures = 0;
		cmp_count = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_config();
		t_coding();
		t_sequence();
		t_rate();
		t_serial();
		t_power();
		t_fifo();
		give_verdict();
	end

	// whole run is near 4400 cycles; this cuts a hang short
	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		give_verdict();
	end
endmodule
